// ### common/cdl_link_if.sv
// lane wires between the sequencer and the far receiver
interface cdl_link_if #(
   parameter int NL = 4
);
   import cdl_pkg::*;

   cdl_lane_t clk_ln;
   cdl_lane_t dat_ln;
   logic [NL*8-1:0] dat_byte;
   logic clk_term_en;
   logic dat_term_en;

   modport tx (
      output clk_ln,
      output dat_ln,
      output dat_byte
   );

   modport rx (
      input clk_ln,
      input dat_ln,
      input dat_byte,
      output clk_term_en,
      output dat_term_en
   );
endinterface

// ### common/cdl_pkg.sv
// shared lane codes, commands, timing figures and the cycle helper
package cdl_pkg;

   // ==========================================
   // lane codes and commands
   typedef enum logic [2:0] {
      LN_LP11,
      LN_LP01,
      LN_LP10,
      LN_LP00,
      LN_HS0,
      LN_HSCLK,
      LN_HSDATA,
      LN_HSTRAIL
   } cdl_lane_t;

   typedef enum logic [1:0] {
      CMD_BURST,
      CMD_ULPS,
      CMD_WAKE
   } cdl_cmd_t;

   // ==========================================
   // widths and fixed values
   localparam int UI_PS_DEF = 1500;
   localparam int BYTE_UI = 8;
   localparam int TMR_W = 20;
   localparam int LEN_W = 16;
   localparam logic [7:0] SYNC_BYTE = 8'hB8;

   // ==========================================
   // transmitter times (ns plus multiples of ui; init in us, wake in ms)
   localparam int T_LPX_NS = 50;
   localparam int T_CPREP_NS = 38;
   localparam int T_CPZ_NS = 300;
   localparam int T_CPRE_UI = 8;
   localparam int T_CTRAIL_NS = 60;
   localparam int T_CPOST_NS = 60;
   localparam int T_CPOST_UI = 52;
   localparam int T_DPREP_NS = 40;
   localparam int T_DPREP_UI = 4;
   localparam int T_DPZ_NS = 145;
   localparam int T_DPZ_UI = 10;
   localparam int T_DTRAIL_NS = 60;
   localparam int T_DTRAIL_UI = 4;
   localparam int T_HSEXIT_NS = 100;
   localparam int T_INIT_US = 100;
   localparam int T_WAKE_MS = 1;

   // ==========================================
   // receiver times
   localparam int T_CMISS_NS = 60;
   localparam int T_CSET_NS = 95;
   localparam int T_DSET_NS = 85;
   localparam int T_DSET_UI = 6;

   // ==========================================
   // time to byte-clock cycles, rounded up, never below one
   function automatic int cyc_up(input int ns, input int ui, input int ui_ps);
      int t;
      int c;
      t = ns * 1000 + ui * ui_ps;
      c = (t + BYTE_UI * ui_ps - 1) / (BYTE_UI * ui_ps);
      return (c < 1) ? 1 : c;
   endfunction

endpackage

// ### hw/cdl_rx.sv
// far receiver: termination, settle, skip and clock-miss windows
module cdl_rx #(
   parameter int NL = 4,
   parameter int UI_PS = cdl_pkg::UI_PS_DEF
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic lkclk_i,
   cdl_link_if.rx lk,
   output logic done_o,
   output logic [cdl_pkg::LEN_W-1:0] beats_o,
   output logic err_o,
   output logic clk_on_o
);
   import cdl_pkg::*;

   localparam int C_CSET = cyc_up(T_CSET_NS, 0, UI_PS);
   localparam int C_DSET = cyc_up(T_DSET_NS, T_DSET_UI, UI_PS);
   localparam int C_CMISS = cyc_up(T_CMISS_NS, 0, UI_PS);

   // ==========================================
   // link domain
   logic rst_s1_ff, lrst_n_ff;
   cdl_lane_t cprev_ff, dprev_ff;
   logic clk_term_ff, dat_term_ff, clk_on_ff, rcv_ff, seen_ff, err_ff;
   logic [7:0] cset_ff, dset_ff, miss_ff, exp_ff;
   logic [LEN_W-1:0] cnt_ff, res_cnt_ff;
   logic res_err_ff, done_tgl_ff;
   logic bad;

   wire c_entry = lk.clk_ln == LN_LP00 && cprev_ff != LN_LP00;
   wire d_entry = lk.dat_ln == LN_LP00 && dprev_ff != LN_LP00;
   wire c_hs = lk.clk_ln == LN_HSCLK;
   wire settled = dset_ff == 8'h00 && dat_term_ff && clk_on_ff;
   wire sync_hit = settled && !rcv_ff && lk.dat_ln == LN_HSDATA
      && lk.dat_byte[7:0] == SYNC_BYTE;
   wire take = rcv_ff && lk.dat_ln == LN_HSDATA;
   wire trail = seen_ff && lk.dat_ln == LN_HSTRAIL;

   assign lk.clk_term_en = clk_term_ff;
   assign lk.dat_term_en = dat_term_ff;

   always_comb begin
      bad = 1'b0;
      for (int i = 0; i < NL; i++) begin
         if (lk.dat_byte[i*8 +: 8] != exp_ff + 8'(i)) bad = 1'b1;
      end
   end

   always_ff @(posedge lkclk_i) begin
      rst_s1_ff <= resetn_i;
      lrst_n_ff <= rst_s1_ff;
   end

   always_ff @(posedge lkclk_i) begin
      if (!lrst_n_ff) begin
         cprev_ff <= LN_LP11;
         dprev_ff <= LN_LP11;
         clk_term_ff <= 1'b0;
         dat_term_ff <= 1'b0;
         clk_on_ff <= 1'b0;
         cset_ff <= 8'h00;
         dset_ff <= 8'h00;
         miss_ff <= 8'h00;
      end else begin
         cprev_ff <= lk.clk_ln;
         dprev_ff <= lk.dat_ln;
         // termination one cycle after lp-00, well inside the limit
         if (lk.clk_ln == LN_LP00) clk_term_ff <= 1'b1;
         else if (lk.clk_ln == LN_LP11) clk_term_ff <= 1'b0;
         if (lk.dat_ln == LN_LP00) dat_term_ff <= 1'b1;
         else if (lk.dat_ln == LN_LP11) dat_term_ff <= 1'b0;
         if (c_entry) cset_ff <= 8'(C_CSET);
         else if (cset_ff != 8'h00) cset_ff <= cset_ff - 8'h01;
         if (d_entry) dset_ff <= 8'(C_DSET);
         else if (dset_ff != 8'h00) dset_ff <= dset_ff - 8'h01;
         miss_ff <= (clk_on_ff && !c_hs) ? miss_ff + 8'h01 : 8'h00;
         if (clk_on_ff && !c_hs && miss_ff == 8'(C_CMISS - 1)) clk_on_ff <= 1'b0;
         else if (c_hs && cset_ff == 8'h00 && clk_term_ff) clk_on_ff <= 1'b1;
      end
   end

   always_ff @(posedge lkclk_i) begin
      if (!lrst_n_ff) begin
         rcv_ff <= 1'b0;
         seen_ff <= 1'b0;
         err_ff <= 1'b0;
         exp_ff <= 8'h00;
         cnt_ff <= '0;
         res_cnt_ff <= '0;
         res_err_ff <= 1'b0;
         done_tgl_ff <= 1'b0;
      end else begin
         if (d_entry) seen_ff <= 1'b1;
         if (sync_hit) begin
            rcv_ff <= 1'b1;
            err_ff <= 1'b0;
            exp_ff <= 8'h00;
            cnt_ff <= '0;
         end
         if (take) begin
            err_ff <= err_ff | bad;
            exp_ff <= exp_ff + 8'h01;
            cnt_ff <= cnt_ff + LEN_W'(1);
         end
         // trail: stop sampling, lane ignored until the next lp-00 entry
         if (trail) begin
            rcv_ff <= 1'b0;
            seen_ff <= 1'b0;
            res_cnt_ff <= rcv_ff ? cnt_ff : '0;
            res_err_ff <= err_ff | ~rcv_ff;
            done_tgl_ff <= ~done_tgl_ff;
         end
      end
   end

   // ==========================================
   // user domain; results stand still between bursts
   logic dn_s1_ff, dn_s2_ff, dn_s3_ff, on_s1_ff, on_s2_ff;
   logic done_ff, err_o_ff;
   logic [LEN_W-1:0] beats_ff;
   wire dn_edge = dn_s2_ff ^ dn_s3_ff;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         dn_s1_ff <= 1'b0;
         dn_s2_ff <= 1'b0;
         dn_s3_ff <= 1'b0;
         on_s1_ff <= 1'b0;
         on_s2_ff <= 1'b0;
         done_ff <= 1'b0;
         err_o_ff <= 1'b0;
         beats_ff <= '0;
      end else begin
         dn_s1_ff <= done_tgl_ff;
         dn_s2_ff <= dn_s1_ff;
         dn_s3_ff <= dn_s2_ff;
         on_s1_ff <= clk_on_ff;
         on_s2_ff <= on_s1_ff;
         done_ff <= dn_edge;
         if (dn_edge) begin
            beats_ff <= res_cnt_ff;
            err_o_ff <= res_err_ff;
         end
      end
   end

   assign done_o = done_ff;
   assign beats_o = beats_ff;
   assign err_o = err_o_ff;
   assign clk_on_o = on_s2_ff;
endmodule

// ### hw/cdl_tx.sv
// lane sequencing timer: clock and data lane state transmitter
//
// Operation
// - clock runs 8 ui before data entry
// - clock prepare 38-95 ns, plus zero 300
// - clock trail hs-0 at least 60 ns
// - data prepare window, prepare plus zero floor
// - data trail floor, trail to lp-11 cap
// - lp-11 at least 100 ns after burst
// - lp-01 and ulps entry steps last 5 byte clocks, at least 50 ns
// - mark-1 wake held at least 1 ms
// - receiver drops clock after 60 ns quiet
// - receiver ignores clock for settle window
// - receiver ignores data for settle window
// - receiver skips data after burst end
// - receiver data termination within 35+4ui
// - receiver clock termination within 38 ns
// - one to four lanes, ui 0.6-2.7 ns
module cdl_tx #(
   parameter int NL = 4,
   parameter int UI_PS = cdl_pkg::UI_PS_DEF,
   parameter int INIT_CYC = cdl_pkg::cyc_up(cdl_pkg::T_INIT_US * 1000, 0, UI_PS),
   parameter int WAKE_CYC = cdl_pkg::cyc_up(cdl_pkg::T_WAKE_MS * 1000000, 0, UI_PS)
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic lkclk_i,
   input wire logic burst_req_i,
   input wire logic [cdl_pkg::LEN_W-1:0] burst_len_i,
   input wire logic ulps_req_i,
   input wire logic wake_req_i,
   output logic ready_o,
   output logic in_ulps_o,
   cdl_link_if.tx lk
);
   import cdl_pkg::*;

   // ==========================================
   // phase lengths in byte clocks
   localparam int C_LPX = cyc_up(T_LPX_NS, 0, UI_PS);
   localparam int C_CPREP = cyc_up(T_CPREP_NS, 0, UI_PS);
   localparam int C_CZERO = cyc_up(T_CPZ_NS, 0, UI_PS) - C_CPREP;
   localparam int C_CPRE = cyc_up(0, T_CPRE_UI, UI_PS);
   localparam int C_DPREP = cyc_up(T_DPREP_NS, T_DPREP_UI, UI_PS);
   localparam int C_DZERO = cyc_up(T_DPZ_NS, T_DPZ_UI, UI_PS) - C_DPREP;
   localparam int C_DTRAIL = cyc_up(T_DTRAIL_NS, T_DTRAIL_UI, UI_PS);
   localparam int C_CPOST = cyc_up(T_CPOST_NS, T_CPOST_UI, UI_PS);
   localparam int C_CTRAIL = cyc_up(T_CTRAIL_NS, 0, UI_PS);
   localparam int C_HSEXIT = cyc_up(T_HSEXIT_NS, 0, UI_PS);

   typedef enum logic [4:0] {
      ST_INIT,
      ST_IDLE,
      ST_C_LPX,
      ST_C_PREP,
      ST_C_ZERO,
      ST_C_PRE,
      ST_D_LPX,
      ST_D_PREP,
      ST_D_ZERO,
      ST_D_SYNC,
      ST_D_DATA,
      ST_D_TRAIL,
      ST_D_EXIT,
      ST_C_TRAIL,
      ST_EXIT,
      ST_U_LPX,
      ST_U_LP00,
      ST_ULPS,
      ST_WAKE
   } cdl_txst_t;

   // ==========================================
   // user domain: command handshake
   logic req_tgl_ff, busy_ff, rdy_ff;
   cdl_cmd_t cmd_ff;
   logic [LEN_W-1:0] len_ff;
   logic ack_s1_ff, ack_s2_ff, ack_s3_ff;
   logic idle_s1_ff, idle_s2_ff, ulps_s1_ff, ulps_s2_ff;
   logic ack_tgl_ff, idle_lv_ff, ulps_lv_ff;

   // burst wins over ulps when both arrive together
   wire acc_burst = rdy_ff & ~ulps_s2_ff & burst_req_i;
   wire acc_ulps = rdy_ff & ~ulps_s2_ff & ~burst_req_i & ulps_req_i;
   wire acc_wake = rdy_ff & ulps_s2_ff & wake_req_i;
   wire acc = acc_burst | acc_ulps | acc_wake;
   wire ack_edge = ack_s2_ff ^ ack_s3_ff;
   wire nxt_busy = acc | (busy_ff & ~ack_edge);

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         req_tgl_ff <= 1'b0;
         cmd_ff <= CMD_BURST;
         len_ff <= '0;
         busy_ff <= 1'b0;
         rdy_ff <= 1'b0;
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
         ack_s3_ff <= 1'b0;
         idle_s1_ff <= 1'b0;
         idle_s2_ff <= 1'b0;
         ulps_s1_ff <= 1'b0;
         ulps_s2_ff <= 1'b0;
      end else begin
         if (acc) begin
            req_tgl_ff <= ~req_tgl_ff;
            cmd_ff <= acc_burst ? CMD_BURST : (acc_ulps ? CMD_ULPS : CMD_WAKE);
            len_ff <= burst_len_i;
         end
         busy_ff <= nxt_busy;
         rdy_ff <= idle_s2_ff & ~nxt_busy;
         ack_s1_ff <= ack_tgl_ff;
         ack_s2_ff <= ack_s1_ff;
         ack_s3_ff <= ack_s2_ff;
         idle_s1_ff <= idle_lv_ff;
         idle_s2_ff <= idle_s1_ff;
         ulps_s1_ff <= ulps_lv_ff;
         ulps_s2_ff <= ulps_s1_ff;
      end
   end

   assign ready_o = rdy_ff;
   assign in_ulps_o = ulps_s2_ff;

   // ==========================================
   // link domain: reset and request sync
   logic rst_s1_ff, lrst_n_ff;
   logic rq_s1_ff, rq_s2_ff, rq_s3_ff;

   always_ff @(posedge lkclk_i) begin
      rst_s1_ff <= resetn_i;
      lrst_n_ff <= rst_s1_ff;
   end

   // cmd_ff and len_ff stay still while busy, so they are read directly
   wire req_edge = rq_s2_ff ^ rq_s3_ff;

   // ==========================================
   // sequencer
   cdl_txst_t st_ff, nxt_st;
   logic [TMR_W-1:0] tmr_ff, nxt_tmr;
   int nxt_dur;
   logic [7:0] seq_ff;
   cdl_lane_t clk_ln_ff, dat_ln_ff, nxt_cln, nxt_dln;
   logic [NL*8-1:0] byte_ff, nxt_byte;

   wire tdone = tmr_ff == '0;
   wire go_burst = req_edge && cmd_ff == CMD_BURST;
   wire to_rest = (nxt_st == ST_IDLE || nxt_st == ST_ULPS) && nxt_st != st_ff
      && st_ff != ST_INIT;
   wire ack_ev = to_rest | (req_edge & (nxt_st == st_ff));

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_INIT: if (tdone) nxt_st = ST_IDLE;
         ST_IDLE: begin
            if (go_burst) nxt_st = ST_C_LPX;
            else if (req_edge && cmd_ff == CMD_ULPS) nxt_st = ST_U_LPX;
         end
         ST_C_LPX: if (tdone) nxt_st = ST_C_PREP;
         ST_C_PREP: if (tdone) nxt_st = ST_C_ZERO;
         ST_C_ZERO: if (tdone) nxt_st = ST_C_PRE;
         ST_C_PRE: if (tdone) nxt_st = ST_D_LPX;
         ST_D_LPX: if (tdone) nxt_st = ST_D_PREP;
         ST_D_PREP: if (tdone) nxt_st = ST_D_ZERO;
         ST_D_ZERO: if (tdone) nxt_st = ST_D_SYNC;
         ST_D_SYNC: nxt_st = ST_D_DATA;
         ST_D_DATA: if (tdone) nxt_st = ST_D_TRAIL;
         ST_D_TRAIL: if (tdone) nxt_st = ST_D_EXIT;
         ST_D_EXIT: if (tdone) nxt_st = ST_C_TRAIL;
         ST_C_TRAIL: if (tdone) nxt_st = ST_EXIT;
         ST_EXIT: if (tdone) nxt_st = ST_IDLE;
         ST_U_LPX: if (tdone) nxt_st = ST_U_LP00;
         ST_U_LP00: if (tdone) nxt_st = ST_ULPS;
         ST_ULPS: if (req_edge && cmd_ff == CMD_WAKE) nxt_st = ST_WAKE;
         ST_WAKE: if (tdone) nxt_st = ST_EXIT;
         default: nxt_st = ST_INIT;
      endcase
   end

   always_comb begin
      case (nxt_st)
         ST_C_LPX, ST_D_LPX, ST_U_LPX, ST_U_LP00: nxt_dur = C_LPX;
         ST_C_PREP: nxt_dur = C_CPREP;
         ST_C_ZERO: nxt_dur = C_CZERO;
         ST_C_PRE: nxt_dur = C_CPRE;
         ST_D_PREP: nxt_dur = C_DPREP;
         ST_D_ZERO: nxt_dur = C_DZERO;
         ST_D_DATA: nxt_dur = (len_ff == '0) ? 1 : int'(len_ff);
         ST_D_TRAIL: nxt_dur = C_DTRAIL;
         ST_D_EXIT: nxt_dur = C_CPOST;
         ST_C_TRAIL: nxt_dur = C_CTRAIL;
         ST_EXIT: nxt_dur = C_HSEXIT;
         ST_WAKE: nxt_dur = WAKE_CYC;
         default: nxt_dur = 1;
      endcase
      // reload on every state change so each phase gets its full count
      if (nxt_st != st_ff) nxt_tmr = TMR_W'(nxt_dur - 1);
      else if (tdone) nxt_tmr = tmr_ff;
      else nxt_tmr = tmr_ff - TMR_W'(1);
   end

   // lane codes follow the state one cycle later, clock and data together
   always_comb begin
      case (st_ff)
         ST_C_LPX: nxt_cln = LN_LP01;
         ST_C_PREP, ST_U_LP00, ST_ULPS: nxt_cln = LN_LP00;
         ST_C_ZERO, ST_C_TRAIL: nxt_cln = LN_HS0;
         ST_C_PRE, ST_D_LPX, ST_D_PREP, ST_D_ZERO: nxt_cln = LN_HSCLK;
         ST_D_SYNC, ST_D_DATA, ST_D_TRAIL, ST_D_EXIT: nxt_cln = LN_HSCLK;
         ST_U_LPX, ST_WAKE: nxt_cln = LN_LP10;
         default: nxt_cln = LN_LP11;
      endcase
      case (st_ff)
         ST_D_LPX: nxt_dln = LN_LP01;
         ST_D_PREP, ST_U_LP00, ST_ULPS: nxt_dln = LN_LP00;
         ST_D_ZERO: nxt_dln = LN_HS0;
         ST_D_SYNC, ST_D_DATA: nxt_dln = LN_HSDATA;
         ST_D_TRAIL: nxt_dln = LN_HSTRAIL;
         ST_U_LPX, ST_WAKE: nxt_dln = LN_LP10;
         default: nxt_dln = LN_LP11;
      endcase
   end

   // payload is a counting pattern, lane i carrying count plus i
   always_comb begin
      nxt_byte = '0;
      for (int i = 0; i < NL; i++) begin
         if (st_ff == ST_D_SYNC) nxt_byte[i*8 +: 8] = SYNC_BYTE;
         else if (st_ff == ST_D_DATA) nxt_byte[i*8 +: 8] = seq_ff + 8'(i);
      end
   end

   always_ff @(posedge lkclk_i) begin
      if (!lrst_n_ff) begin
         rq_s1_ff <= 1'b0;
         rq_s2_ff <= 1'b0;
         rq_s3_ff <= 1'b0;
         st_ff <= ST_INIT;
         tmr_ff <= TMR_W'(INIT_CYC - 1);
         seq_ff <= 8'h00;
         clk_ln_ff <= LN_LP11;
         dat_ln_ff <= LN_LP11;
         byte_ff <= '0;
         ack_tgl_ff <= 1'b0;
         idle_lv_ff <= 1'b0;
         ulps_lv_ff <= 1'b0;
      end else begin
         rq_s1_ff <= req_tgl_ff;
         rq_s2_ff <= rq_s1_ff;
         rq_s3_ff <= rq_s2_ff;
         st_ff <= nxt_st;
         tmr_ff <= nxt_tmr;
         seq_ff <= (st_ff == ST_D_DATA) ? seq_ff + 8'h01 : 8'h00;
         clk_ln_ff <= nxt_cln;
         dat_ln_ff <= nxt_dln;
         byte_ff <= nxt_byte;
         ack_tgl_ff <= ack_tgl_ff ^ ack_ev;
         idle_lv_ff <= nxt_st == ST_IDLE || nxt_st == ST_ULPS;
         ulps_lv_ff <= nxt_st == ST_ULPS;
      end
   end

   assign lk.clk_ln = clk_ln_ff;
   assign lk.dat_ln = dat_ln_ff;
   assign lk.dat_byte = byte_ff;
endmodule

// ### testbench/cdl_props.sv
// lane timing assertions on the link between sequencer and receiver
module cdl_props #(
   parameter int NL = 4,
   parameter int INIT_CYC = 20,
   parameter int WAKE_CYC = 30
) (
   input wire logic lkclk_i,
   input wire logic resetn_i,
   input wire cdl_pkg::cdl_lane_t clk_ln,
   input wire cdl_pkg::cdl_lane_t dat_ln,
   input wire logic [NL*8-1:0] dat_byte,
   input wire logic clk_term_en,
   input wire logic dat_term_en
);
   import cdl_pkg::*;
   // ==========
   // run lengths in byte cycles, saturating so a long sleep cannot wrap
   cdl_lane_t cl_ff;
   cdl_lane_t dl_ff;
   logic [15:0] cr_ff, cp_ff, dr_ff, dp_ff, up_ff;
   wire cc = clk_ln != cl_ff;
   wire dc = dat_ln != dl_ff;
   always_ff @(posedge lkclk_i) begin
      if (!resetn_i) begin
         cl_ff <= LN_LP11;
         dl_ff <= LN_LP11;
         {cr_ff, cp_ff, dr_ff, dp_ff, up_ff} <= '0;
      end else begin
         cl_ff <= clk_ln;
         dl_ff <= dat_ln;
         cr_ff <= cc ? 16'h0001 : cr_ff + {15'h0000, ~&cr_ff};
         dr_ff <= dc ? 16'h0001 : dr_ff + {15'h0000, ~&dr_ff};
         cp_ff <= cc ? cr_ff : cp_ff;
         dp_ff <= dc ? dr_ff : dp_ff;
         up_ff <= up_ff + {15'h0000, ~&up_ff};
      end
   end
   // ==========
   // figures hold for a 12 ns byte clock only
   default clocking cb @(posedge lkclk_i);
   endclocking
   default disable iff (!resetn_i);
   chk_clk_pre_run:
   assert property (dc && dl_ff == LN_LP11 && dat_ln == LN_LP01 |-> cl_ff == LN_HSCLK)
      else $error("data entry before clock");
   chk_clk_prep:
   assert property (cc && cl_ff == LN_LP00 && clk_ln == LN_HS0 |-> cr_ff inside {[4:7]})
      else $error("clock prepare length");
   chk_clk_zero:
   assert property (cc && cl_ff == LN_HS0 && clk_ln == LN_HSCLK |-> cr_ff + cp_ff >= 16'h0019)
      else $error("clock prepare plus zero short");
   chk_clk_trail:
   assert property (cc && cl_ff == LN_HS0 && clk_ln == LN_LP11 |-> cr_ff >= 16'h0005)
      else $error("clock trail short");
   chk_dat_prep:
   assert property (dc && dl_ff == LN_LP00 && dat_ln == LN_HS0 |-> dr_ff inside {[4:7]})
      else $error("data prepare length");
   chk_dat_zero:
   assert property (dc && dl_ff == LN_HS0 |-> dat_ln == LN_HSDATA && dr_ff + dp_ff >= 16'h000E)
      else $error("data prepare plus zero short");
   chk_dat_trail:
   assert property (dc && dl_ff == LN_HSTRAIL |-> dat_ln == LN_LP11 && dr_ff inside {[6:10]})
      else $error("data trail length");
   chk_stop_hold:
   assert property (cc && cl_ff == LN_LP11 |-> cr_ff >= 16'h0009)
      else $error("stop state too short");
   chk_lp_len:
   assert property ((cc && cl_ff inside {LN_LP01, LN_LP10} |-> cr_ff >= 16'h0005)
      and (dc && dl_ff inside {LN_LP01, LN_LP10} |-> dr_ff >= 16'h0005))
      else $error("low power state too short");
   chk_wake_len:
   assert property (cc && cl_ff == LN_LP10 && clk_ln == LN_LP11 |-> cr_ff >= 16'(WAKE_CYC))
      else $error("wake too short");
   chk_dat_term:
   assert property (dc && dl_ff == LN_LP01 && dat_ln == LN_LP00 |=> dat_term_en [*3])
      else $error("data termination late");
   chk_clk_term:
   assert property (cc && cl_ff == LN_LP01 && clk_ln == LN_LP00 |=> $rose(clk_term_en))
      else $error("clock termination late");
   chk_init_idle:
   assert property (up_ff < 16'(INIT_CYC)
      |-> clk_ln == LN_LP11 && dat_ln == LN_LP11 && dat_byte == '0)
      else $error("lanes busy during init");
   cov_burst: cover property (dc && dl_ff == LN_HSTRAIL);
   cov_wake: cover property (cc && cl_ff == LN_LP10 && clk_ln == LN_LP11);
   cov_term: cover property (clk_term_en && dat_term_en);
endmodule

// ### testbench/tb_top.sv
// bench: sequencer and receiver joined across the lane interface
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cdl_pkg::*;
   localparam int NL = 4;
   localparam int INIT_CYC = 20;
   localparam int WAKE_CYC = 30;
   localparam int W_RDY = 0;
   localparam int W_DONE = 1;
   localparam int W_ULPS = 2;
   logic clk_i, lkclk_i, resetn_i, burst_req_i, ulps_req_i, wake_req_i;
   logic ready_o, in_ulps_o, done_o, err_o, clk_on_o;
   logic [LEN_W-1:0] burst_len_i, beats_o;
   int miscompares = 0;
   int n_tests = 0;
   int exp_len = 1;
   int k = -1;
   int n;
   int lens[4] = '{0, 1, 7, 40};
   cdl_link_if #(.NL(NL)) lk_if ();
   cdl_tx #(.NL(NL), .INIT_CYC(INIT_CYC), .WAKE_CYC(WAKE_CYC)) cdl_tx_inst (
      .clk_i(clk_i), .resetn_i(resetn_i), .lkclk_i(lkclk_i), .burst_req_i(burst_req_i),
      .burst_len_i(burst_len_i), .ulps_req_i(ulps_req_i), .wake_req_i(wake_req_i),
      .ready_o(ready_o), .in_ulps_o(in_ulps_o), .lk(lk_if.tx));
   cdl_rx #(.NL(NL)) cdl_rx_inst (.clk_i(clk_i), .resetn_i(resetn_i), .lkclk_i(lkclk_i),
      .lk(lk_if.rx), .done_o(done_o), .beats_o(beats_o), .err_o(err_o), .clk_on_o(clk_on_o));
   cdl_props #(.NL(NL), .INIT_CYC(INIT_CYC), .WAKE_CYC(WAKE_CYC)) cdl_props_inst (
      .lkclk_i(lkclk_i), .resetn_i(resetn_i), .clk_ln(lk_if.clk_ln), .dat_ln(lk_if.dat_ln),
      .dat_byte(lk_if.dat_byte), .clk_term_en(lk_if.clk_term_en),
      .dat_term_en(lk_if.dat_term_en));
   // ==========
   // clocks: byte clock offset so the two never line up
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      lkclk_i = 1'b0;
      #3.7;
      forever #6 lkclk_i = ~lkclk_i;
   end
   // ==========
   // helpers
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // bounded wait on a result pin picked by number; n keeps the cycle count
   function automatic logic pick(input int sel);
      return (sel == W_RDY) ? ready_o : ((sel == W_DONE) ? done_o : in_ulps_o);
   endfunction
   task automatic wait_sig(input int sel, input logic v, input int lim);
      for (n = 0; n < lim && pick(sel) !== v; n++) begin
         @(posedge clk_i);
      end
      if (pick(sel) !== v) begin
         cmp_val(32'(pick(sel)), 32'(v));
         close_out();
      end
   endtask
   // second edge lets ready fall before anyone looks again
   task automatic request(input logic b, input logic u, input logic w);
      burst_req_i <= b;
      ulps_req_i <= u;
      wake_req_i <= w;
      @(posedge clk_i);
      {burst_req_i, ulps_req_i, wake_req_i} <= 3'h0;
      @(posedge clk_i);
   endtask
   task automatic burst(input int len, input logic u);
      wait_sig(W_RDY, 1'b1, 2000);
      exp_len = (len == 0) ? 1 : len;
      burst_len_i <= len[LEN_W-1:0];
      request(1'b1, u, 1'b0);
      wait_sig(W_DONE, 1'b1, 1000);
      cmp_val(32'(beats_o), exp_len);
      cmp_val(32'({err_o, clk_on_o, in_ulps_o}), 32'h2);
      wait_sig(W_RDY, 1'b1, 2000);
      cmp_val(32'(clk_on_o), 32'h0);
   endtask
   // ==========
   // wire watch: sync byte, then counting pattern per lane
   always @(posedge lkclk_i) begin
      if (resetn_i !== 1'b1) begin
         k = -1;
      end else if (lk_if.dat_ln === LN_HSDATA) begin
         for (int i = 0; i < NL; i++) begin
            cmp_val(32'(lk_if.dat_byte[i*8+:8]),
               (k < 0) ? 32'(SYNC_BYTE) : 32'((k + i) % 256));
         end
         k++;
      end else begin
         if (k >= 0) cmp_val(k, exp_len);
         k = -1;
      end
   end
   // ==========
   // main sequence
   initial begin
      resetn_i = 1'b0;
      {burst_req_i, ulps_req_i, wake_req_i} = 3'h0;
      burst_len_i = 16'h0000;
      repeat (3) @(posedge clk_i);
      cmp_val(32'({ready_o, lk_if.clk_ln, lk_if.dat_ln}), 32'({1'b0, LN_LP11, LN_LP11}));
      resetn_i <= 1'b1;
      wait_sig(W_RDY, 1'b1, 200);
      cmp_val(32'(n * 20 >= INIT_CYC * 12), 32'h1);
      foreach (lens[j]) begin
         burst(lens[j], 1'b0);
      end
      burst(3, 1'b1);
      request(1'b0, 1'b0, 1'b1);
      cmp_val(32'({ready_o, in_ulps_o}), 32'h2);
      // sleep, a refused burst, then wake
      request(1'b0, 1'b1, 1'b0);
      wait_sig(W_ULPS, 1'b1, 500);
      wait_sig(W_RDY, 1'b1, 500);
      request(1'b1, 1'b0, 1'b0);
      cmp_val(32'({ready_o, in_ulps_o}), 32'h3);
      request(1'b0, 1'b0, 1'b1);
      wait_sig(W_RDY, 1'b1, 500);
      cmp_val(32'((n + 2) * 20 >= (WAKE_CYC + 9) * 12), 32'h1);
      cmp_val(32'(in_ulps_o), 32'h0);
      burst(2, 1'b0);
      // reset lands in mid-burst, lanes must fall back to idle
      burst_len_i <= 16'h0020;
      request(1'b1, 1'b0, 1'b0);
      repeat (20) @(posedge clk_i);
      resetn_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      cmp_val(32'({ready_o, lk_if.clk_ln, lk_if.dat_ln}), 32'({1'b0, LN_LP11, LN_LP11}));
      resetn_i <= 1'b1;
      burst(9, 1'b0);
      close_out();
   end
endmodule
